// file: dv/laac_sensor_model.sv
// level sensor front end and fill valve load
`timescale 1ns/1ns
module laac_sensor_model (
	// clock
	input wire logic clk_sys,
	// valve solenoid load
	input wire logic valve_on,
	// level front end
	output logic [15:0] level_ch0,
	output logic [15:0] level_ch1,
	output logic sample_tgl,
	output logic sensor_lost
);
	// quiet sensor at power up
	initial
	begin
		level_ch0 = 16'h0000;
		level_ch1 = 16'hffff;
		sample_tgl = 1'b0;
		sensor_lost = 1'b0;
	end
	// word settles a cycle before the toggle and stays for the settle time
	task automatic put(input logic [15:0] v);
		@(posedge clk_sys);
		level_ch0 <= v;
		level_ch1 <= ~v;
		@(posedge clk_sys);
		sample_tgl <= ~sample_tgl;
		repeat (12) @(posedge clk_sys);
	endtask
	// loss-of-sensor flag, changed right after an edge
	task automatic set_lost(input logic v);
		@(posedge clk_sys);
		sensor_lost <= v;
	endtask
	// bounded wait for the solenoid to reach a level
	task automatic wait_valve(input logic v);
		for (int n = 0; n < 20; n++)
		begin
			@(posedge clk_sys);
			if (valve_on === v)
				break;
		end
	endtask
endmodule // laac_sensor_model

// file: dv/tb_top.sv
// self-checking bench for the level alarm and autofill controller
`timescale 1ns/1ns
module tb_top;
	logic clk_sys = 1'b0;
	logic srst = 1'b1;
	logic psel = 1'b0;
	logic penable = 1'b0;
	logic pwrite = 1'b0;
	logic [7:0] paddr = 8'h00;
	logic [31:0] pwdata = 32'h0;
	logic [31:0] prdata;
	logic pready, pslverr, valve_on, buzzer, alarm_ind, timeout_ind;
	logic [1:0] relay_closed;
	logic [15:0] level_ch0, level_ch1;
	logic sample_tgl, sensor_lost, er;
	logic [31:0] rd;
	int miscompares = 0;
	int cmp_count = 0;
	always #5 clk_sys = ~clk_sys;
	laac_ctrl #(.LW(16), .MIN_CYC(10)) DUT (.clk_sys(clk_sys),
		.srst(srst), .psel(psel), .penable(penable), .pwrite(pwrite),
		.paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
		.pslverr(pslverr), .level_ch0(level_ch0), .level_ch1(level_ch1),
		.sample_tgl(sample_tgl), .sensor_lost(sensor_lost),
		.valve_on(valve_on), .relay_closed(relay_closed), .buzzer(buzzer),
		.alarm_ind(alarm_ind), .timeout_ind(timeout_ind));
	laac_sensor_model sens (.clk_sys(clk_sys), .valve_on(valve_on),
		.level_ch0(level_ch0), .level_ch1(level_ch1),
		.sample_tgl(sample_tgl), .sensor_lost(sensor_lost));
	task automatic stop_test();
		if (miscompares == 0 && cmp_count > 0)
			$display("NO MISMATCHES");
		else
			$display("MISMATCHES SEEN");
		$finish;
	endtask
	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		cmp_count++;
		if (got !== exp)
		begin
			miscompares++;
			$display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask
	// one apb transfer, held until pready is seen at an edge
	task automatic apb(input logic w, input logic [7:0] a,
		input logic [31:0] d);
		int n;
		@(posedge clk_sys);
		psel <= 1'b1;
		pwrite <= w;
		paddr <= a;
		pwdata <= d;
		@(posedge clk_sys);
		penable <= 1'b1;
		for (n = 0; n < 20; n++)
		begin
			@(posedge clk_sys);
			if (pready === 1'b1)
				break;
		end
		if (n == 20)
		begin
			miscompares++;
			stop_test();
		end
		rd = prdata;
		er = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
	endtask
	function automatic logic [31:0] outs();
		return {26'h0, valve_on, relay_closed, buzzer, alarm_ind, timeout_ind};
	endfunction
	task automatic t_reset();
		chk(outs(), 32'h0);
		apb(1'b0, laac_pkg::OFS_STATUS, 32'h0);
		chk(rd, 32'h0);
		apb(1'b0, 8'h20, 32'h0);
		chk(er, 1'b1);
		chk(rd, 32'h0);
	endtask
	task automatic t_alarm();
		apb(1'b1, laac_pkg::OFS_ALM0, 32'h0001_0064);
		sens.put(16'h0032);
		chk({alarm_ind, buzzer}, 2'b11);
		apb(1'b1, laac_pkg::OFS_CTRL, 32'h0000_0008);
		repeat (3) @(posedge clk_sys);
		chk({alarm_ind, buzzer}, 2'b10);
		apb(1'b1, laac_pkg::OFS_ALM1, 32'h0005_0028);
		sens.put(16'h0032);
		chk(buzzer, 1'b1);
		sens.put(16'h0096);
		apb(1'b0, laac_pkg::OFS_STATUS, 32'h0);
		chk(rd[1:0], 2'b10);
		apb(1'b1, laac_pkg::OFS_ALM0, 32'h0);
		apb(1'b1, laac_pkg::OFS_ALM1, 32'h0);
	endtask
	task automatic t_relay();
		apb(1'b1, laac_pkg::OFS_RLY0, 32'h0005_00c8);
		apb(1'b1, laac_pkg::OFS_RLY1, 32'h0004_0000);
		sens.put(16'h00fa);
		chk(relay_closed, 2'b01);
		sens.put(16'h0096);
		chk(relay_closed, 2'b00);
		apb(1'b1, laac_pkg::OFS_RLY1, 32'h0006_1000);
		repeat (3) @(posedge clk_sys);
		chk(relay_closed, 2'b10);
	endtask
	task automatic t_fill();
		apb(1'b1, laac_pkg::OFS_FILLSP, 32'h012c_0064);
		apb(1'b1, laac_pkg::OFS_FILLCFG, 32'h0001_0000);
		sens.put(16'h0032);
		chk(valve_on, 1'b0);
		apb(1'b1, laac_pkg::OFS_CTRL, 32'h0000_0001);
		apb(1'b1, laac_pkg::OFS_CTRL, 32'h0000_0005);
		sens.put(16'h0032);
		chk(valve_on, 1'b1);
		sens.put(16'h00c8);
		repeat (40) @(posedge clk_sys);
		chk({valve_on, timeout_ind}, 2'b10);
		sens.put(16'h015e);
		chk(valve_on, 1'b0);
		apb(1'b1, laac_pkg::OFS_FILLCFG, 32'h0001_0001);
		sens.put(16'h0032);
		repeat (20) @(posedge clk_sys);
		chk({valve_on, timeout_ind, buzzer}, 3'b011);
		apb(1'b1, laac_pkg::OFS_CTRL, 32'h0000_0003);
		apb(1'b1, laac_pkg::OFS_CTRL, 32'h0000_0007);
		repeat (3) @(posedge clk_sys);
		chk({valve_on, timeout_ind}, 2'b00);
		apb(1'b1, laac_pkg::OFS_FILLCFG, 32'h0001_0000);
		apb(1'b1, laac_pkg::OFS_CTRL, 32'h0000_0001);
		apb(1'b1, laac_pkg::OFS_CTRL, 32'h0000_0005);
		repeat (3) @(posedge clk_sys);
		chk(valve_on, 1'b1);
		sens.set_lost(1'b1);
		sens.wait_valve(1'b0);
		chk(valve_on, 1'b0);
		sens.set_lost(1'b0);
		apb(1'b1, laac_pkg::OFS_CTRL, 32'h0000_0002);
		apb(1'b1, laac_pkg::OFS_CTRL, 32'h0000_0006);
		repeat (3) @(posedge clk_sys);
		chk(valve_on, 1'b1);
		apb(1'b1, laac_pkg::OFS_ALM0, 32'h0005_0028);
		repeat (3) @(posedge clk_sys);
		chk(valve_on, 1'b0);
		apb(1'b1, laac_pkg::OFS_ALM0, 32'h0);
		apb(1'b1, laac_pkg::OFS_CTRL, 32'h0000_0010);
		apb(1'b0, laac_pkg::OFS_CTRL, 32'h0);
		chk(rd[1:0], 2'h3);
		apb(1'b1, laac_pkg::OFS_CTRL, 32'h0000_0010);
		apb(1'b0, laac_pkg::OFS_CTRL, 32'h0);
		chk(rd[1:0], 2'h0);
		apb(1'b0, laac_pkg::OFS_STATUS, 32'h0);
		chk(rd[10:9], 2'h2);
	endtask
	// main sequence
	initial
	begin
		repeat (2) @(posedge clk_sys);
		srst <= 1'b0;
		t_reset();
		t_alarm();
		t_relay();
		t_fill();
		stop_test();
	end
endmodule // tb_top

// file: rtl/laac_ctrl.sv
// level alarms, relays, annunciator and autofill valve control
// Behaviour
// - two level alarms, own source and setpoint
// - alarm direction le or ge setpoint
// - any alarm drives annunciator and indicator
// - alarm indicator high, status shows all alarms
// - two relays, own setpoint and source
// - relay closes when comparison holds
// - disabled relay source stays open
// - alarms never latch
// - mute holds until alarm set changes
// - any alarm change clears mute
// - fill timer raises timeout when the minute interval is reached
// - timeout closes valve, sounds, indicates
// - zero minute interval disables watchdog
// - controller rests off until a selection is saved
// - four states stepped by selection
// - auto keeps level between start and stop
// - manual open, ge fill alarm closes
// - manual closed valve off, off no control
// - sensor loss halts auto fill
// - auto or closed save clears timeout
`timescale 1ns/1ns
module laac_ctrl #(
	parameter int LW = 16,
	parameter longint MIN_CYC = laac_pkg::MINUTE_CYC
) (
	// clock and reset
	input wire logic clk_sys,
	input wire logic srst,
	// apb slave
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [7:0] paddr,
	input wire logic [31:0] pwdata,
	output logic [31:0] prdata,
	output logic pready,
	output logic pslverr,
	// level front end, asynchronous
	input wire logic [LW-1:0] level_ch0,
	input wire logic [LW-1:0] level_ch1,
	input wire logic sample_tgl,
	input wire logic sensor_lost,
	// outputs
	output logic valve_on,
	output logic [1:0] relay_closed,
	output logic buzzer,
	output logic alarm_ind,
	output logic timeout_ind
);
	// configuration words and internal state
	logic [31:0] cfg_alm [2];
	logic [31:0] cfg_rly [2];
	logic [31:0] fill_sp;
	logic [31:0] fill_cfg;
	logic [LW-1:0] l0_a, l0_b, l1_a, l1_b, lv0, lv1;
	logic t_a, t_b, t_c, lost_a, lost_b;
	logic new_sample;
	logic [1:0] alm, alm_prev;
	logic muted;
	logic tmo_q, tmo_rise;
	laac_pkg::laac_fill_t fstate;
	logic [1:0] pend_sel;
	logic filling, tmo;
	logic [15:0] min_cnt;
	longint cyc_cnt;
	logic wr, rd_acc;
	logic [31:0] next_prdata;

	// two-flop sync of level bus, sample toggle and loss flag
	always_ff @(posedge clk_sys)
	begin
		l0_a <= level_ch0;
		l0_b <= l0_a;
		l1_a <= level_ch1;
		l1_b <= l1_a;
		t_a <= sample_tgl;
		t_b <= t_a;
		t_c <= t_b;
		lost_a <= sensor_lost;
		lost_b <= lost_a;
	end
	assign new_sample = t_b ^ t_c;

	// latch both levels on the sample edge so all compare the same value
	always_ff @(posedge clk_sys)
	begin
		if (srst)
		begin
			lv0 <= '0;
			lv1 <= '0;
		end
		else if (new_sample)
		begin
			lv0 <= l0_b;
			lv1 <= l1_b;
		end
	end

	// shared compare; a disabled source never asserts
	function automatic logic laac_cmp(input logic [31:0] c,
		input logic [LW-1:0] a, input logic [LW-1:0] b);
		logic [LW-1:0] lv;
		logic [LW-1:0] sp;
		lv = (c[laac_pkg::SRC_LSB +: 2] == laac_pkg::SRC_CH1) ? b : a;
		sp = c[laac_pkg::SP_LSB +: LW];
		if (c[laac_pkg::SRC_LSB +: 2] == laac_pkg::SRC_OFF)
			return 1'b0;
		else if (c[laac_pkg::DIR_BIT])
			return lv >= sp;
		else
			return lv <= sp;
	endfunction

	// alarms and relays evaluated every cycle from the held sample
	genvar gi;
	generate
		for (gi = 0; gi < 2; gi++)
		begin : g_cmp
			always_ff @(posedge clk_sys)
			begin
				if (srst)
				begin
					alm[gi] <= 1'b0;
					relay_closed[gi] <= 1'b0;
				end
				else
				begin
					alm[gi] <= laac_cmp(cfg_alm[gi], lv0, lv1);
					relay_closed[gi] <= laac_cmp(cfg_rly[gi], lv0, lv1);
				end
			end
		end
	endgenerate

	// mute: set by request, cleared by any alarm change (change wins)
	always_ff @(posedge clk_sys)
	begin
		if (srst)
		begin
			alm_prev <= 2'h0;
			muted <= 1'b0;
		end
		else
		begin
			alm_prev <= alm;
			if (alm != alm_prev || tmo_rise)
				muted <= 1'b0;
			else if (wr && paddr == laac_pkg::OFS_CTRL &&
				pwdata[laac_pkg::CTRL_MUTE_BIT])
				muted <= 1'b1;
		end
	end

	// timeout rise counts as an alarm change for the mute
	always_ff @(posedge clk_sys)
	begin
		if (srst)
			tmo_q <= 1'b0;
		else
			tmo_q <= tmo;
	end
	assign tmo_rise = tmo & ~tmo_q;

	// annunciator and indicators
	always_ff @(posedge clk_sys)
	begin
		if (srst)
		begin
			buzzer <= 1'b0;
			alarm_ind <= 1'b0;
			timeout_ind <= 1'b0;
		end
		else
		begin
			buzzer <= (|alm | tmo) & ~muted;
			alarm_ind <= |alm | tmo;
			timeout_ind <= tmo;
		end
	end

	// apb decode; zero wait state
	assign wr = psel & penable & pwrite;
	assign rd_acc = psel & ~penable & ~pwrite;
	logic save, step;
	assign save = wr && paddr == laac_pkg::OFS_CTRL &&
		pwdata[laac_pkg::CTRL_SAVE_BIT];
	assign step = wr && paddr == laac_pkg::OFS_CTRL &&
		pwdata[laac_pkg::CTRL_STEP_BIT];

	always_ff @(posedge clk_sys)
	begin
		if (srst)
		begin
			cfg_alm[0] <= laac_pkg::RST_ZERO;
			cfg_alm[1] <= laac_pkg::RST_ZERO;
			cfg_rly[0] <= laac_pkg::RST_ZERO;
			cfg_rly[1] <= laac_pkg::RST_ZERO;
			fill_sp <= laac_pkg::RST_ZERO;
			fill_cfg <= laac_pkg::RST_ZERO;
		end
		else if (wr)
		begin
			case (paddr)
				laac_pkg::OFS_ALM0: cfg_alm[0] <= pwdata;
				laac_pkg::OFS_ALM1: cfg_alm[1] <= pwdata;
				laac_pkg::OFS_RLY0: cfg_rly[0] <= pwdata;
				laac_pkg::OFS_RLY1: cfg_rly[1] <= pwdata;
				laac_pkg::OFS_FILLSP: fill_sp <= pwdata;
				laac_pkg::OFS_FILLCFG: fill_cfg <= pwdata;
				default: ;
			endcase
		end
	end

	// pending selection steps through four states, committed on save
	always_ff @(posedge clk_sys)
	begin
		if (srst)
			pend_sel <= laac_pkg::FS_OFF;
		else if (step)
			pend_sel <= pend_sel + 2'h1;
		else if (wr && paddr == laac_pkg::OFS_CTRL)
			pend_sel <= pwdata[laac_pkg::CTRL_SEL_LSB +: 2];
	end

	// committed fill state, off after reset until saved
	always_ff @(posedge clk_sys)
	begin
		if (srst)
			fstate <= laac_pkg::LAAC_OFF;
		else if (save)
			fstate <= laac_pkg::laac_fill_t'(pend_sel);
	end

	// fill level follows the configured fill source
	logic [LW-1:0] flv;
	assign flv = (fill_cfg[laac_pkg::FSRC_LSB +: 2] == laac_pkg::SRC_CH1)
		? lv1 : lv0;
	// any active ge alarm on the fill channel overrides manual open
	logic ge_fill_alm;
	always_comb
	begin
		ge_fill_alm = 1'b0;
		for (int i = 0; i < 2; i++)
			if (alm[i] && cfg_alm[i][laac_pkg::DIR_BIT] &&
				cfg_alm[i][laac_pkg::SRC_LSB +: 2] ==
				fill_cfg[laac_pkg::FSRC_LSB +: 2])
				ge_fill_alm = 1'b1;
	end

	// autonomous hysteresis: open at start, close at stop
	always_ff @(posedge clk_sys)
	begin
		if (srst)
			filling <= 1'b0;
		else if (fstate != laac_pkg::LAAC_AUTO || tmo || lost_b)
			filling <= 1'b0;
		else if (flv >= fill_sp[31:16])
			filling <= 1'b0;
		else if (flv <= fill_sp[15:0])
			filling <= 1'b1;
	end

	// fill watchdog in whole minutes; interval zero disables it
	always_ff @(posedge clk_sys)
	begin
		if (srst)
		begin
			cyc_cnt <= 0;
			min_cnt <= 16'h0;
			tmo <= 1'b0;
		end
		else if (save && (pend_sel == laac_pkg::FS_AUTO ||
			pend_sel == laac_pkg::FS_MCLOSED))
		begin
			tmo <= 1'b0;
			cyc_cnt <= 0;
			min_cnt <= 16'h0;
		end
		else if (!filling || fill_cfg[15:0] == 16'h0)
		begin
			cyc_cnt <= 0;
			min_cnt <= 16'h0;
		end
		else if (cyc_cnt == MIN_CYC - 1)
		begin
			cyc_cnt <= 0;
			min_cnt <= min_cnt + 16'h1;
			if (min_cnt + 16'h1 >= fill_cfg[15:0])
				tmo <= 1'b1;
		end
		else
			cyc_cnt <= cyc_cnt + 1;
	end

	// valve drive per fill state
	always_ff @(posedge clk_sys)
	begin
		if (srst)
			valve_on <= 1'b0;
		else
		begin
			case (fstate)
				laac_pkg::LAAC_AUTO: valve_on <= filling & ~tmo;
				laac_pkg::LAAC_MOPEN: valve_on <= ~ge_fill_alm;
				laac_pkg::LAAC_MCLOSED: valve_on <= 1'b0;
				default: valve_on <= 1'b0;
			endcase
		end
	end

	// read mux, taken in setup so data stands during access
	always_comb
	begin
		case (paddr)
			laac_pkg::OFS_ALM0: next_prdata = cfg_alm[0];
			laac_pkg::OFS_ALM1: next_prdata = cfg_alm[1];
			laac_pkg::OFS_RLY0: next_prdata = cfg_rly[0];
			laac_pkg::OFS_RLY1: next_prdata = cfg_rly[1];
			laac_pkg::OFS_FILLSP: next_prdata = fill_sp;
			laac_pkg::OFS_FILLCFG: next_prdata = fill_cfg;
			laac_pkg::OFS_CTRL: next_prdata = {30'h0, pend_sel};
			laac_pkg::OFS_STATUS: next_prdata = {21'h0, fstate, filling,
				tmo, muted, buzzer, valve_on, relay_closed, alm};
			default: next_prdata = 32'h0;
		endcase
	end

	// registered response; read data frozen at setup for the access edge
	always_ff @(posedge clk_sys)
	begin
		if (srst)
		begin
			prdata <= 32'h0;
			pready <= 1'b0;
			pslverr <= 1'b0;
		end
		else
		begin
			if (rd_acc)
				prdata <= next_prdata;
			pready <= psel & ~penable;
			pslverr <= psel & ~penable & (paddr[1:0] != 2'h0 ||
				paddr > laac_pkg::OFS_STATUS);
		end
	end

	// checks
	a_relay_off_dis: assert property (@(posedge clk_sys) disable iff (srst)
		cfg_rly[0][laac_pkg::SRC_LSB +: 2] == laac_pkg::SRC_OFF
		|=> !relay_closed[0]) else $error("disabled relay closed");
	a_mute_cleared: assert property (@(posedge clk_sys) disable iff (srst)
		alm != $past(alm) |=> !muted) else $error("mute kept");
	a_tmo_valve: assert property (@(posedge clk_sys) disable iff (srst)
		tmo && fstate == laac_pkg::LAAC_AUTO |=> !valve_on)
		else $error("valve open on timeout");
	a_zero_tmo: assert property (@(posedge clk_sys) disable iff (srst)
		fill_cfg[15:0] == 16'h0 |=> min_cnt == 16'h0)
		else $error("watchdog ran at zero");
	a_mclosed: assert property (@(posedge clk_sys) disable iff (srst)
		fstate == laac_pkg::LAAC_MCLOSED |=> !valve_on)
		else $error("valve open in closed");
	a_mopen_ge: assert property (@(posedge clk_sys) disable iff (srst)
		fstate == laac_pkg::LAAC_MOPEN && ge_fill_alm |=> !valve_on)
		else $error("ge alarm ignored");
	a_lost_halt: assert property (@(posedge clk_sys) disable iff (srst)
		lost_b |=> !filling) else $error("fill on sensor loss");
	a_buzz_alarm: assert property (@(posedge clk_sys) disable iff (srst)
		(|alm) && !muted |=> buzzer) else $error("silent alarm");
endmodule // laac_ctrl

// file: rtl/laac_pkg.sv
// package of constants for the level alarm and autofill controller
package laac_pkg;
	// register byte offsets
	localparam logic [7:0] OFS_ALM0 = 8'h00;
	localparam logic [7:0] OFS_ALM1 = 8'h04;
	localparam logic [7:0] OFS_RLY0 = 8'h08;
	localparam logic [7:0] OFS_RLY1 = 8'h0c;
	localparam logic [7:0] OFS_FILLSP = 8'h10;
	localparam logic [7:0] OFS_FILLCFG = 8'h14;
	localparam logic [7:0] OFS_CTRL = 8'h18;
	localparam logic [7:0] OFS_STATUS = 8'h1c;
	// channel-setpoint register fields
	localparam int SP_LSB = 0;
	localparam int SRC_LSB = 16;
	localparam int DIR_BIT = 18;
	// source codes: 0 disabled, 1 first channel, 2 second channel
	localparam logic [1:0] SRC_OFF = 2'h0;
	localparam logic [1:0] SRC_CH0 = 2'h1;
	localparam logic [1:0] SRC_CH1 = 2'h2;
	// fill config fields
	localparam int TMO_LSB = 0;
	localparam int FSRC_LSB = 16;
	// ctrl fields
	localparam int CTRL_SEL_LSB = 0;
	localparam int CTRL_SAVE_BIT = 2;
	localparam int CTRL_MUTE_BIT = 3;
	localparam int CTRL_STEP_BIT = 4;
	// fill states in commit encoding
	localparam logic [1:0] FS_OFF = 2'h0;
	localparam logic [1:0] FS_AUTO = 2'h1;
	localparam logic [1:0] FS_MOPEN = 2'h2;
	localparam logic [1:0] FS_MCLOSED = 2'h3;
	// minute timebase
	localparam int MINUTE_S = 60;
	localparam int CLK_HZ = 100000000;
	localparam longint MINUTE_CYC = longint'(MINUTE_S) * CLK_HZ;
	localparam logic [31:0] RST_ZERO = 32'h0000_0000;
	typedef enum logic [1:0] {LAAC_OFF, LAAC_AUTO, LAAC_MOPEN, LAAC_MCLOSED}
		laac_fill_t;
endpackage
